// File: phy_clock_led_reset_control.sv
// Clock forwarding, indicator, strap, reset and power-down/interrupt logic
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
// Offsets, fields and timing counts; guarded, so a second inclusion is harmless
`include "phy_hk_cfg.svh"
module phy_clock_led_reset_control
   import phy_hk_pkg::*;
#(
   parameter int BLINK_CYC = `BLINK_CYC
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Reference clock pins
   input  wire logic        ref_clock_in,
   output logic             crystal_drive_out,
   output logic             system_clock_out,
   // Line status from the transceiver core, and the RMII strap input
   input  wire logic        link_good,
   input  wire logic        speed_100,
   input  wire logic        tx_active,
   input  wire logic        rx_active,
   input  wire logic        collision,
   input  wire logic        full_duplex,
   input  wire logic        strap_rmii_in,
   // Indicator pins, strap inputs during reset
   input  wire logic        link_indicator_in,
   output logic             link_indicator_out,
   output logic             link_indicator_oe,
   input  wire logic        speed_indicator_in,
   output logic             speed_indicator_out,
   output logic             speed_indicator_oe,
   input  wire logic        activity_collision_indicator_in,
   output logic             activity_collision_indicator_out,
   output logic             activity_collision_indicator_oe,
   // Shared power-down / interrupt pin
   input  wire logic        powerdown_irq_pin_in,
   output logic             powerdown_irq_pin_out,
   output logic             powerdown_irq_pin_oe,
   // Core control and interrupt
   output logic             powerdown,
   output logic             rmii_mode,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Constants
   // Counter end points are cut to their register widths on purpose
   // Blink period must fit in BW bits

   localparam int             BW         = `BLINK_W;
   localparam logic [BW-1:0]  BLINK_LAST = BW'(BLINK_CYC - 1);
   localparam logic [BW-1:0]  BLINK_HALF = BW'(BLINK_CYC / 2);
   localparam logic [15:0]    INIT_LAST  = 16'(`RESET_INIT_CYC - 1);
   localparam logic           MII_DIV    = 1'(`MII_HALF_CYC - 1);
   localparam logic           RMII_DIV   = 1'(`RMII_HALF_CYC - 1);
   // Value of every flip-flop after reset
   localparam hk_state_t      RESET_ST   = '{phase: INIT,
                                             ctrl: `CTRL_RESET,
                                             irq_mask: `MASK_RESET,
                                             default: '0};

   ////////////////////////////////////////////////////////////////////////////
   // State

   hk_state_t st;              // Registered state
   hk_state_t next_st;         // Next state
   logic      run;             // Normal operation after straps
   logic      irq_mode;        // Shared pin used as interrupt
   logic [1:0] led_mode;       // Indicator mode
   logic      accept;          // Bus address phase taken
   logic      act;             // Any line activity
   logic      blink_off;       // Dark half of a blink
   logic [3:0] events;         // New interrupt events
   logic [3:0] rd_clr;         // Status bits cleared by a read
   logic [3:0] pend;           // Unmasked pending events

   assign run      = (st.phase == RUN);
   assign irq_mode = st.ctrl[`CTRL_IRQ_BIT];
   assign led_mode = st.ctrl[`CTRL_MODE_LSB +: 2];
   assign accept   = hsel && htrans[1] && hready;
   assign act      = tx_active || rx_active;
   assign pend     = st.irq_status & st.irq_mask;
   assign blink_off = (st.blink_cnt != '0) && (st.blink_cnt <= BLINK_HALF);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      next_st = st;
      events  = '0;
      rd_clr  = '0;

      // Power-up sequence: wait, sample straps, run
      case (st.phase)
         INIT: begin
            if (st.init_cnt == INIT_LAST) begin
               next_st.phase = LATCH;
            end else begin
               next_st.init_cnt = st.init_cnt + 16'h0001;
            end
         end
         LATCH: begin
            next_st.rmii    = strap_rmii_in;
            next_st.an_en   = activity_collision_indicator_in;
            next_st.an_sel1 = speed_indicator_in;
            next_st.an_sel0 = link_indicator_in;
            next_st.phase   = RUN;
         end
         RUN: begin
            next_st.phase = RUN;
         end
         default: begin
            next_st.phase = INIT;
         end
      endcase

      next_st.xtal = ~ref_clock_in;

      // Divider for forwarded clock
      // Greater-or-equal: when the strap switches to RMII with the count at one,
      // the output still toggles on that edge and never skips a half period
      if (st.div_cnt >= (st.rmii ? RMII_DIV : MII_DIV)) begin
         next_st.div_cnt = 1'b0;
         next_st.sysclk  = ~st.sysclk;
      end else begin
         next_st.div_cnt = ~st.div_cnt;
      end

      // Blink timer, restarts on new activity
      next_st.act_q = act;
      if (act && !st.act_q) begin
         next_st.blink_cnt = BW'(1);
      end else if (st.blink_cnt == BLINK_LAST) begin
         next_st.blink_cnt = act ? BW'(1) : '0;
      end else if (st.blink_cnt != '0) begin
         next_st.blink_cnt = st.blink_cnt + BW'(1);
      end

      // Pin is an input unless reconfigured
      next_st.pin_q = powerdown_irq_pin_in;
      next_st.pd    = run && !irq_mode && !powerdown_irq_pin_in;

      // Indicator drive, dark while powered down
      if (!run || st.pd) begin
         next_st.link_indicator  = 1'b0;
         next_st.speed_indicator = 1'b0;
         next_st.led_act   = 1'b0;
      end else begin
         next_st.speed_indicator = speed_100;
         case (led_mode)
            2'h2: begin
               next_st.link_indicator = link_good && !blink_off;
               next_st.led_act  = collision;
            end
            2'h3: begin
               next_st.link_indicator = link_good && !blink_off;
               next_st.led_act  = st.ctrl[`CTRL_DUP_BIT] ? full_duplex : collision;
            end
            default: begin
               next_st.link_indicator = link_good;
               next_st.led_act  = act;
            end
         endcase
      end

      // Event detection for the interrupt status
      next_st.link_q  = link_good;
      next_st.speed_q = speed_100;
      next_st.col_q   = collision;
      if (run) begin
         events[`IRQ_LINK_BIT]  = link_good != st.link_q;
         events[`IRQ_SPEED_BIT] = speed_100 != st.speed_q;
         events[`IRQ_COL_BIT]   = collision && !st.col_q;
         events[`IRQ_PDREQ_BIT] = !irq_mode && st.pin_q && !powerdown_irq_pin_in;
      end

      // Data phase of a write
      if (st.ph_valid && st.ph_wr) begin
         if (st.ph_addr == `REG_CTRL) begin
            next_st.ctrl = hwdata[3:0];
         end else if (st.ph_addr == `REG_IRQ_MASK) begin
            next_st.irq_mask = hwdata[3:0];
         end
      end

      // Address phase of a transfer
      next_st.ph_valid = accept;
      next_st.ph_wr    = hwrite;
      next_st.ph_addr  = haddr[7:0];
      if (accept && !hwrite) begin
         // Reads see a write that is still in its data phase
         if (haddr[7:0] == `REG_CTRL) begin
            next_st.rdata = {28'h0000000, next_st.ctrl};
         end else if (haddr[7:0] == `REG_STATUS) begin
            next_st.rdata = {24'h000000, run, st.an_sel0, st.an_sel1,
                             st.an_en, st.rmii, st.pd, speed_100, link_good};
         end else if (haddr[7:0] == `REG_IRQ_STATUS) begin
            next_st.rdata = {28'h0000000, st.irq_status};
            rd_clr        = 4'hF;
         end else if (haddr[7:0] == `REG_IRQ_MASK) begin
            next_st.rdata = {28'h0000000, next_st.irq_mask};
         end else begin
            next_st.rdata = 32'h00000000;
         end
      end

      // Sticky status: a new event beats the read clear
      next_st.irq_status = (st.irq_status & ~rd_clr) | events;

      // Pull low only while an enabled event is pending
      next_st.irq    = |(next_st.irq_status & next_st.irq_mask);
      next_st.pin_oe = next_st.ctrl[`CTRL_IRQ_BIT] && next_st.irq;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   // Straps and registers are rebuilt from scratch by every reset
   // Reset branch loads constants only

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= RESET_ST;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // All data outputs except hreadyout, hresp and powerdown_irq_pin_out, which are constants, come straight from the state register
   // The shared pin only ever pulls low; the pull-up gives the high level

   assign hreadyout                        = 1'b1;
   assign hresp                            = 1'b0;
   assign hrdata                           = st.rdata;
   assign crystal_drive_out                = st.xtal;
   assign system_clock_out                 = st.sysclk;
   assign link_indicator_out               = st.link_indicator;
   assign speed_indicator_out              = st.speed_indicator;
   assign activity_collision_indicator_out = st.led_act;
   // Pins released until straps are taken
   assign link_indicator_oe                = run;
   assign speed_indicator_oe               = run;
   assign activity_collision_indicator_oe  = run;
   assign powerdown_irq_pin_out            = 1'b0;
   assign powerdown_irq_pin_oe             = st.pin_oe;
   assign powerdown                        = st.pd;
   assign rmii_mode                        = st.rmii;
   assign irq                              = st.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Properties watch design state and outputs, several of them against the inputs
   // All checks are quiet while reset is held

   init_length_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st.phase == INIT && st.init_cnt != INIT_LAST |=> st.phase == INIT)
      else $error("Init ended early");

   strap_oe_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st.phase != RUN |-> !link_indicator_oe && !speed_indicator_oe)
      else $error("Indicator driven before straps");

   rmii_clock_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st.rmii && $past(st.rmii) |-> system_clock_out != $past(system_clock_out))
      else $error("RMII clock not 50 MHz");

   mii_clock_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !st.rmii && $rose(system_clock_out) |=> system_clock_out ##1 !system_clock_out)
      else $error("MII clock not 25 MHz");

   link_mode1_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run && !st.pd && led_mode == 2'h1 |=> link_indicator_out == $past(link_good))
      else $error("Mode 1 link indicator wrong");

   speed_led_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run && !st.pd |=> speed_indicator_out == $past(speed_100))
      else $error("Speed indicator wrong");

   act_mode1_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run && !st.pd && led_mode == 2'h1 |=> activity_collision_indicator_out == $past(act))
      else $error("Mode 1 activity wrong");

   col_mode2_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run && !st.pd && led_mode == 2'h2 |=>
         activity_collision_indicator_out == $past(collision))
      else $error("Mode 2 collision wrong");

   dup_mode3_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run && !st.pd && led_mode == 2'h3 && st.ctrl[`CTRL_DUP_BIT] |=>
         activity_collision_indicator_out == $past(full_duplex))
      else $error("Mode 3 duplex wrong");

   blink_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      act && !st.act_q |=> st.blink_cnt == BW'(1) ##1 st.blink_cnt == BW'(2))
      else $error("Blink not restarted");

   powerdown_in_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run && !irq_mode && !powerdown_irq_pin_in |=> powerdown)
      else $error("Power-down request missed");

   pin_input_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !irq_mode |-> !powerdown_irq_pin_oe)
      else $error("Pin driven in power-down mode");

   pin_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
      powerdown_irq_pin_oe |-> irq && !powerdown_irq_pin_out)
      else $error("Pin driven without interrupt");

   // Pending enabled interrupt must pull the pin once it is set as interrupt
   pin_pull_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_mode && irq |-> powerdown_irq_pin_oe && !powerdown_irq_pin_out)
      else $error("Interrupt not on the pin");

   // Powered down means every indicator dark
   leds_dark_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st.pd |=> !link_indicator_out && !speed_indicator_out
         && !activity_collision_indicator_out)
      else $error("Indicator lit in power-down");

   // Dark half of a blink in mode 2
   blink_dark_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run && !st.pd && led_mode == 2'h2 && blink_off |=> !link_indicator_out)
      else $error("Link indicator not blinking");

   // Strap taken fresh in the latch cycle
   strap_take_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st.phase == LATCH |=> rmii_mode == $past(strap_rmii_in))
      else $error("RMII strap not captured");

endmodule

// File: phy_hk_cfg.svh
// Offsets, field positions, reset values and timing counts of the housekeeping block
`ifndef PHY_HK_CFG_SVH
`define PHY_HK_CFG_SVH
// Register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STATUS  8'h08
`define REG_IRQ_MASK    8'h0C
// Control fields
`define CTRL_MODE_LSB   0
`define CTRL_DUP_BIT    2
`define CTRL_IRQ_BIT    3
`define CTRL_RESET      4'h1
`define MASK_RESET      4'h0
// Interrupt event bits
`define IRQ_LINK_BIT    0
`define IRQ_SPEED_BIT   1
`define IRQ_COL_BIT     2
`define IRQ_PDREQ_BIT   3
// Status fields
`define ST_LINK_BIT     0
`define ST_SPEED_BIT    1
`define ST_PD_BIT       2
`define ST_RMII_BIT     3
`define ST_ANEN_BIT     4
`define ST_AN1_BIT      5
`define ST_AN0_BIT      6
`define ST_RUN_BIT      7
// Timing
`define CLK_MHZ         100
`define REF_MII_MHZ     25
`define REF_RMII_MHZ    50
`define MII_HALF_CYC    (`CLK_MHZ / (2 * `REF_MII_MHZ))
`define RMII_HALF_CYC   (`CLK_MHZ / (2 * `REF_RMII_MHZ))
`define RESET_MIN_NS    1000
`define RESET_INIT_CYC  ((`RESET_MIN_NS * `CLK_MHZ + 999) / 1000)
`define BLINK_MS        50
`define BLINK_CYC       (`BLINK_MS * `CLK_MHZ * 1000)
`define BLINK_W         24
`endif

// File: phy_hk_pkg.sv
// Types of the housekeeping block
package phy_hk_pkg;
`include "phy_hk_cfg.svh"
   // Sequence after hardware reset
   typedef enum logic [1:0] {INIT, LATCH, RUN} phase_t;
   // Whole state of the block
   typedef struct packed {
      phase_t              phase;
      logic [15:0]         init_cnt;
      logic                rmii;
      logic                an_en;
      logic                an_sel1;
      logic                an_sel0;
      logic [3:0]          ctrl;
      logic [3:0]          irq_status;
      logic [3:0]          irq_mask;
      logic                div_cnt;
      logic                sysclk;
      logic                xtal;
      logic [`BLINK_W-1:0] blink_cnt;
      logic                act_q;
      logic                link_q;
      logic                speed_q;
      logic                col_q;
      logic                pin_q;
      logic                pd;
      logic                link_indicator;
      logic                speed_indicator;
      logic                led_act;
      logic                irq;
      logic                pin_oe;
      logic                ph_valid;
      logic                ph_wr;
      logic [7:0]          ph_addr;
      logic [31:0]         rdata;
   } hk_state_t;
endpackage

// File: phy_board_model.sv
// Board model: reset source, strap resistors, indicator loads and shared-pin pull-up
`timescale 1ns/10ps
module phy_board_model #(
   parameter int RST_CYC = 100   // Requested reset length, 1 us at 100 MHz
) (
   // Clock and requests from the bench
   input  wire logic       hclk,
   input  wire logic       rst_req,
   input  wire logic [3:0] straps,
   input  wire logic       pd_req,
   // Pins driven by the block
   input  wire logic       rmii_mode,
   input  wire logic [2:0] led_out,
   input  wire logic [2:0] led_oe,
   input  wire logic       pin_out,
   input  wire logic       pin_oe,
   // Levels seen by the block
   output logic            hresetn,
   output logic [2:0]      led_level,
   output logic            pin_level,
   output logic            ref_clk
);
   int   rst_cnt = 5;     // Cycles of reset still to hold, short at power-up
   logic half    = 1'b0;  // Divider phase for the MII rate

   ////////////////////////////////////////////////////////////////////////////////
   // reset held long enough
   always @(posedge hclk) begin
      if (rst_req) begin
         rst_cnt <= RST_CYC;
      end else if (rst_cnt > 0) begin
         rst_cnt <= rst_cnt - 1;
      end
   end
   assign hresetn = (rst_cnt == 0);

   ////////////////////////////////////////////////////////////////////////////////
   // reference at 25 or 50 MHz
   initial ref_clk = 1'b0;
   always @(posedge hclk) begin
      half <= ~half;
      if (rmii_mode || half) begin
         ref_clk <= ~ref_clk;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // strap resistors when undriven
   assign led_level = (led_oe & led_out) | (~led_oe & straps[2:0]);
   assign pin_level = ~((pin_oe & ~pin_out) | pd_req);
endmodule

// File: phy_clock_led_reset_control_test.sv
// Self-checking bench of the clock, indicator, reset and shared-pin block
`timescale 1ns/10ps
`include "phy_hk_cfg.svh"
module phy_clock_led_reset_control_test;
   import phy_hk_pkg::*;
   localparam int BLINK = 20;  // Short blink period
   // Bus, clock and reset
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   // Line status inputs and block outputs
   logic        link_good, speed_100, tx_active, rx_active, collision, full_duplex;
   logic        ref_clock_in, crystal_drive_out, system_clock_out, powerdown, rmii_mode, irq;
   logic        link_indicator_out, speed_indicator_out, activity_collision_indicator_out;
   logic        link_indicator_oe, speed_indicator_oe, activity_collision_indicator_oe;
   logic        powerdown_irq_pin_out, powerdown_irq_pin_oe, pin_level, pd_req, rst_req;
   logic [2:0]  led_level;
   logic [3:0]  straps;
   logic [5:0]  leds;
   int          error_cnt, comparisons, cycles;
   assign leds = {activity_collision_indicator_oe, speed_indicator_oe, link_indicator_oe,
                  activity_collision_indicator_out, speed_indicator_out, link_indicator_out};

   ////////////////////////////////////////////////////////////////////////////////
   phy_clock_led_reset_control #(.BLINK_CYC(BLINK)) phy_clock_led_reset_control_inst (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hreadyout, .hrdata, .hresp, .ref_clock_in, .crystal_drive_out, .system_clock_out,
      .link_good, .speed_100, .tx_active, .rx_active, .collision, .full_duplex,
      .strap_rmii_in(straps[3]), .link_indicator_in(led_level[0]), .link_indicator_out,
      .link_indicator_oe, .speed_indicator_in(led_level[1]), .speed_indicator_out,
      .speed_indicator_oe, .activity_collision_indicator_in(led_level[2]),
      .activity_collision_indicator_out, .activity_collision_indicator_oe,
      .powerdown_irq_pin_in(pin_level), .powerdown_irq_pin_out, .powerdown_irq_pin_oe,
      .powerdown, .rmii_mode, .irq);
   phy_board_model phy_board_model_inst (
      .hclk, .rst_req, .straps, .pd_req, .rmii_mode, .pin_level,
      .led_out(leds[2:0]), .led_oe(leds[5:3]), .pin_out(powerdown_irq_pin_out),
      .pin_oe(powerdown_irq_pin_oe), .hresetn, .led_level, .ref_clk(ref_clock_in));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   // Wait n edges, then step past them
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   // One single AHB-Lite word transfer, read data left in rd
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
      #1;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
      ahb(1'b0, a, 32'h0);
      check(rd, want);
   endtask
   // Expected status word from straps and line inputs
   function automatic logic [31:0] stat_exp(input logic pd);
      return {24'h0, 1'b1, straps[0], straps[1], straps[2], straps[3], pd, speed_100, link_good};
   endfunction
   // Expected enables and indicators when no blink runs
   function automatic logic [5:0] led_exp(input int m, input int dup);
      logic act;
      act = (m < 2) ? (tx_active | rx_active) : ((m == 3 && dup != 0) ? full_duplex : collision);
      return {3'b111, act, speed_100, link_good};
   endfunction
   // Count output clock toggles over 40 cycles and follow the crystal drive
   task automatic clk_chk(input int toggles);
      int   n;
      logic prev_clk, prev_ref;
      n = 0;
      prev_clk = system_clock_out;
      prev_ref = ref_clock_in;
      repeat (40) begin
         tick(1);
         n += (system_clock_out !== prev_clk);
         check({31'h0, crystal_drive_out}, {31'h0, ~prev_ref});
         prev_clk = system_clock_out;
         prev_ref = ref_clock_in;
      end
      check(n, toggles);
   endtask
   // Counts, verdict and end of run
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Cut a hang short
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int dup;
      {hsel, hwrite, htrans, haddr, hwdata, hsize} = {4'h0, 64'h0, 3'h2};
      {link_good, speed_100, tx_active, rx_active, collision, full_duplex} = 6'h00;
      {rst_req, pd_req, straps} = 6'h05;
      void'($urandom(97));
      tick(12);
      check(leds[5:3], 3'h0);
      tick(100);
      rdchk(`REG_STATUS, stat_exp(1'b0));
      rdchk(`REG_CTRL, `CTRL_RESET);
      rdchk(`REG_IRQ_MASK, `MASK_RESET);
      rdchk(`REG_IRQ_STATUS, 32'h0);
      rdchk(8'h10, 32'h0);
      clk_chk(20);
      $display("test reset and straps done");
      // Every indicator mode with random line status
      for (int m = 0; m < 4; m++) begin
         dup = $urandom_range(1);
         {tx_active, rx_active} <= 2'b00;
         ahb(1'b1, `REG_CTRL, 32'(m | (dup << 2)));
         tick(BLINK + 5);
         repeat (6) begin
            {link_good, speed_100, collision, full_duplex} <= 4'($urandom);
            {tx_active, rx_active} <= (m < 2) ? 2'($urandom) : 2'b00;
            tick(3);
            check(leds, led_exp(m, dup));
         end
      end
      // Blink on activity with the link up
      {link_good, tx_active, rx_active, collision} <= 4'b1000;
      ahb(1'b1, `REG_CTRL, 32'h2);
      tick(BLINK + 5);
      check(link_indicator_out, 1'b1);
      tx_active <= 1'b1;
      tick(4);
      check(link_indicator_out, 1'b0);
      tx_active <= 1'b0;
      tick(BLINK / 2 + 2);
      check(link_indicator_out, 1'b1);
      tick(BLINK);
      rx_active <= 1'b1;
      tick(4);
      check(link_indicator_out, 1'b0);
      rx_active <= 1'b0;
      $display("test indicators done");
      // Power-down request on the shared pin
      ahb(1'b1, `REG_CTRL, 32'h1);
      ahb(1'b0, `REG_IRQ_STATUS, 32'h0);
      pd_req <= 1'b1;
      tick(3);
      check({leds[2:0], powerdown}, 4'h1);
      rdchk(`REG_STATUS, stat_exp(1'b1));
      pd_req <= 1'b0;
      tick(3);
      check(powerdown, 1'b0);
      rdchk(`REG_IRQ_STATUS, 32'h8);
      // Interrupt flagged, on the pin only once selected
      ahb(1'b1, `REG_IRQ_MASK, 32'h1);
      link_good <= 1'b0;
      tick(3);
      check({irq, powerdown_irq_pin_oe}, 2'b10);
      rdchk(`REG_IRQ_STATUS, 32'h1);
      ahb(1'b1, `REG_CTRL, 32'h9);
      link_good <= 1'b1;
      tick(3);
      check({irq, powerdown_irq_pin_oe, pin_level}, 3'b110);
      rdchk(`REG_IRQ_STATUS, 32'h1);
      tick(2);
      check({irq, powerdown_irq_pin_oe, pin_level}, 3'b001);
      ahb(1'b1, `REG_IRQ_MASK, 32'h0);
      speed_100 <= ~speed_100;
      tick(3);
      check({irq, powerdown_irq_pin_oe}, 2'b00);
      rdchk(`REG_IRQ_STATUS, 32'h2);
      $display("test power-down and interrupt done");
      // Mid-run reset with changed straps
      straps <= 4'hA;
      rst_req <= 1'b1;
      tick(1);
      rst_req <= 1'b0;
      tick(95);
      check({leds[5:3], rmii_mode}, 4'h0);
      tick(120);
      rdchk(`REG_CTRL, `CTRL_RESET);
      rdchk(`REG_IRQ_MASK, `MASK_RESET);
      rdchk(`REG_STATUS, stat_exp(1'b0));
      check(rmii_mode, 1'b1);
      clk_chk(40);
      $display("test second reset done");
      close_out();
   end
endmodule
